/* core/serial_status_defs.vh */
// Constants for the serial port status and interrupt-mask unit
// Notes on behaviour
// - Enable write sets mask bits written one
// - Disable write clears mask bits written one
// - Bits 0-7: rx, tx, break, dma, errors
// - Bits 8-13 and modem changes 16-19
// - Manchester source bit 20, flag bit 24
// - Mask view read-only, same bit map
// - Status shows modem levels at 23..20
// - Rx ready set by character, cleared by read
// - Rx ready returns on receiver re-enable
// - Tx ready low: pending char, break, disabled
// - Enabling transmitter makes tx ready one
// - Break flag sticky until reset-status
// - Rx DMA done mirrors channel signal
// - Tx DMA done mirrors channel signal
// - Overrun sticky until reset-status
// - Framing sticky until reset-status
// - Parity sticky until reset-status
// - Time-out flag; zero when value zero
// - Manchester bits only with coder present
// - Reduced variant drops three modem lines
// - Modem change flags cleared by status read
// - Non-ack sticky until reset-nonack command
// - Iteration sticky until reset-repeat command
`ifndef SERIAL_STATUS_DEFS_VH
`define SERIAL_STATUS_DEFS_VH

// Register byte offsets (word aligned)
`define OFS_IRQ_ENABLE_SET   4'h0
`define OFS_IRQ_ENABLE_CLEAR 4'h4
`define OFS_IRQ_ENABLE_VIEW  4'h8
`define OFS_CHANNEL_STATUS   4'hC

// Bit positions
`define BIT_RX_CHAR_AVAIL    0
`define BIT_TX_HOLDING_FREE    1
`define BIT_BRK      2
`define BIT_RX_DMA_DONE    3
`define BIT_TX_DMA_DONE    4
`define BIT_OVR      5
`define BIT_FRAME    6
`define BIT_PAR      7
`define BIT_TOUT     8
`define BIT_TX_ALL_DRAINED  9
`define BIT_ITER     10
`define BIT_TX_DMA_BUFFER_EMPTY   11
`define BIT_RX_DMA_BUFFER_FULL   12
`define BIT_NACK     13
`define BIT_RING_IC  16
`define BIT_DSR_IC   17
`define BIT_DCD_IC   18
`define BIT_CTS_IC   19
`define BIT_MAN_IRQ  20
`define BIT_RING_LVL 20
`define BIT_DSR_LVL  21
`define BIT_DCD_LVL  22
`define BIT_CTS_LVL  23
`define BIT_MAN_FLAG 24

// Reset value of the mask
`define MASK_RESET   32'h00000000

`endif

/* core/serial_port_status_irq_unit.v */
// Status flags, interrupt mask and Wishbone slave of a serial port
//
// The register addresses and register access over Wishbone were decided locally.
`timescale 1ns/1ns
`include "serial_status_defs.vh"

module serial_port_status_irq_unit #(
   parameter HAS_MANCHESTER = 1,
   parameter HAS_FULL_MODEM = 1
) (
   // Clock and reset
   input  wire        clock_in,
   input  wire        nrst_in,
   // Wishbone slave
   input  wire        wb_cyc_in,
   input  wire        wb_stb_in,
   input  wire        wb_we_in,
   input  wire [3:0]  wb_adr_in,
   input  wire [3:0]  wb_sel_in,
   input  wire [31:0] wb_dat_in,
   output reg  [31:0] wb_dat_out,
   output reg         wb_ack_out,
   // Receiver events and state
   input  wire        rx_enabled_in,
   input  wire        rx_char_done_in,
   input  wire        rx_holding_read_in,
   input  wire        rx_busy_in,
   input  wire        break_event_in,
   input  wire        overrun_event_in,
   input  wire        framing_event_in,
   input  wire        parity_event_in,
   input  wire        timeout_event_in,
   input  wire        start_timeout_in,
   input  wire        timeout_zero_in,
   input  wire        nonack_event_in,
   input  wire        iteration_event_in,
   input  wire        manchester_event_in,
   // Transmitter state
   input  wire        tx_enabled_in,
   input  wire        tx_holding_full_in,
   input  wire        start_break_cmd_in,
   input  wire        tx_all_drained_in,
   // Commands
   input  wire        reset_status_cmd_in,
   input  wire        reset_nonack_cmd_in,
   input  wire        reset_repeat_cmd_in,
   // DMA channel signals
   input  wire        rx_dma_done_in,
   input  wire        tx_dma_done_in,
   input  wire        tx_dma_buffer_empty_in,
   input  wire        rx_dma_buffer_full_in,
   // Modem pins, asynchronous
   input  wire        ring_in,
   input  wire        dsr_in,
   input  wire        dcd_in,
   input  wire        cts_in,
   // Interrupt
   output reg         irq_out
);

   // =====================================================================
   // Variant masks
   // =====================================================================
   // Bits absent from a variant never set and read zero
   localparam [31:0] MAN_BITS   = HAS_MANCHESTER ? 32'h00100000 : 32'h00000000;
   localparam [31:0] MODEM_BITS = HAS_FULL_MODEM ? 32'h00070000 : 32'h00000000;
   localparam [31:0] IRQ_VALID  = 32'h00083FFF | MAN_BITS | MODEM_BITS;

   // =====================================================================
   // Modem pin synchronisers
   // =====================================================================
   reg  [3:0] modem_meta;
   reg  [3:0] modem_sync;
   reg  [3:0] modem_prev;
   wire [3:0] modem_pins = {cts_in, dcd_in, dsr_in, ring_in};

   // Two flops before any logic; prev feeds the edge detect
   always @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         modem_meta <= 4'h0;
         modem_sync <= 4'h0;
         modem_prev <= 4'h0;
      end else begin
         modem_meta <= modem_pins;
         modem_sync <= modem_meta;
         modem_prev <= modem_sync;
      end
   end

   // Previous-cycle enables to find rising edges
   reg rx_en_d;
   reg tx_en_d;
   reg rx_pending;   // Character in progress when receiver turned off

   // =====================================================================
   // Wishbone decode
   // =====================================================================
   wire bus_req  = wb_cyc_in & wb_stb_in & ~wb_ack_out;
   wire wr_all   = bus_req & wb_we_in & (wb_sel_in == 4'hF);
   wire wr_set   = wr_all & (wb_adr_in == `OFS_IRQ_ENABLE_SET);
   wire wr_clr   = wr_all & (wb_adr_in == `OFS_IRQ_ENABLE_CLEAR);
   wire rd_stat  = bus_req & ~wb_we_in & (wb_adr_in == `OFS_CHANNEL_STATUS);

   // =====================================================================
   // Flags
   // =====================================================================
   reg         rx_char_avail;
   reg         break_seen_flag;
   reg         overrun_flag;
   reg         framing_flag;
   reg         parity_error_flag;
   reg         timeout_flag;
   reg         nonack_flag;
   reg         iteration_flag;
   reg         manchester_err_flag;
   reg  [3:0]  modem_change;          // cts, dcd, dsr, ring
   reg  [31:0] irq_mask;

   wire [3:0] modem_edge = (modem_sync ^ modem_prev) & {1'b1, {3{HAS_FULL_MODEM != 0}}};

   // Sticky flags: a set in the clearing cycle wins
   always @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rx_char_avail       <= 1'b0;
         rx_pending          <= 1'b0;
         rx_en_d             <= 1'b0;
         tx_en_d             <= 1'b0;
         break_seen_flag     <= 1'b0;
         overrun_flag        <= 1'b0;
         framing_flag        <= 1'b0;
         parity_error_flag   <= 1'b0;
         timeout_flag        <= 1'b0;
         nonack_flag         <= 1'b0;
         iteration_flag      <= 1'b0;
         manchester_err_flag <= 1'b0;
         modem_change        <= 4'h0;
      end else begin
         rx_en_d <= rx_enabled_in;
         tx_en_d <= tx_enabled_in;
         // Remember a character cut off by the disable
         if (rx_en_d && !rx_enabled_in && rx_busy_in)
            rx_pending <= 1'b1;
         else if (rx_enabled_in && !rx_en_d)
            rx_pending <= 1'b0;
         if (rx_char_done_in || (rx_enabled_in && !rx_en_d && rx_pending))
            rx_char_avail <= 1'b1;
         else if (rx_holding_read_in)
            rx_char_avail <= 1'b0;
         if (break_event_in)
            break_seen_flag <= 1'b1;
         else if (reset_status_cmd_in)
            break_seen_flag <= 1'b0;
         if (overrun_event_in)
            overrun_flag <= 1'b1;
         else if (reset_status_cmd_in)
            overrun_flag <= 1'b0;
         if (framing_event_in)
            framing_flag <= 1'b1;
         else if (reset_status_cmd_in)
            framing_flag <= 1'b0;
         if (parity_event_in)
            parity_error_flag <= 1'b1;
         else if (reset_status_cmd_in)
            parity_error_flag <= 1'b0;
         if (timeout_event_in)
            timeout_flag <= 1'b1;
         else if (start_timeout_in)
            timeout_flag <= 1'b0;
         if (nonack_event_in)
            nonack_flag <= 1'b1;
         else if (reset_nonack_cmd_in)
            nonack_flag <= 1'b0;
         if (iteration_event_in)
            iteration_flag <= 1'b1;
         else if (reset_repeat_cmd_in)
            iteration_flag <= 1'b0;
         if (manchester_event_in && HAS_MANCHESTER != 0)
            manchester_err_flag <= 1'b1;
         else if (reset_status_cmd_in)
            manchester_err_flag <= 1'b0;
         // Read clears, but an edge in that cycle survives
         modem_change <= modem_edge | (rd_stat ? 4'h0 : modem_change);
      end
   end

   // =====================================================================
   // Status word
   // =====================================================================
   reg [31:0] status_word;

   // Live and sticky bits gathered on the shared map
   always @* begin
      status_word = 32'h00000000;
      status_word[`BIT_RX_CHAR_AVAIL]   = rx_char_avail & rx_enabled_in;
      status_word[`BIT_TX_HOLDING_FREE]   = tx_enabled_in & ~tx_holding_full_in
                                  & ~start_break_cmd_in;
      status_word[`BIT_BRK]     = break_seen_flag;
      status_word[`BIT_RX_DMA_DONE]   = rx_dma_done_in;
      status_word[`BIT_TX_DMA_DONE]   = tx_dma_done_in;
      status_word[`BIT_OVR]     = overrun_flag;
      status_word[`BIT_FRAME]   = framing_flag;
      status_word[`BIT_PAR]     = parity_error_flag;
      status_word[`BIT_TOUT]    = timeout_flag & ~timeout_zero_in;
      status_word[`BIT_TX_ALL_DRAINED] = tx_all_drained_in & tx_enabled_in;
      status_word[`BIT_ITER]    = iteration_flag;
      status_word[`BIT_TX_DMA_BUFFER_EMPTY]  = tx_dma_buffer_empty_in;
      status_word[`BIT_RX_DMA_BUFFER_FULL]  = rx_dma_buffer_full_in;
      status_word[`BIT_NACK]    = nonack_flag;
      status_word[`BIT_CTS_IC]  = modem_change[3];
      status_word[`BIT_DCD_IC]  = modem_change[2] & (HAS_FULL_MODEM != 0);
      status_word[`BIT_DSR_IC]  = modem_change[1] & (HAS_FULL_MODEM != 0);
      status_word[`BIT_RING_IC] = modem_change[0] & (HAS_FULL_MODEM != 0);
      status_word[`BIT_CTS_LVL] = modem_sync[3];
      status_word[`BIT_DCD_LVL] = modem_sync[2] & (HAS_FULL_MODEM != 0);
      status_word[`BIT_DSR_LVL] = modem_sync[1] & (HAS_FULL_MODEM != 0);
      status_word[`BIT_RING_LVL] = modem_sync[0] & (HAS_FULL_MODEM != 0);
      status_word[`BIT_MAN_FLAG] = manchester_err_flag;
   end

   // Interrupt sources: status map with Manchester moved to bit 20
   wire [31:0] irq_source = {11'h000, status_word[`BIT_MAN_FLAG], status_word[19:0] & 20'hFFFFF};
   wire [31:0] src_clean  = irq_source & IRQ_VALID & ~32'h00F00000 | (irq_source & MAN_BITS);

   // =====================================================================
   // Mask register
   // =====================================================================
   // Set-only and clear-only writes; a same-cycle clash cannot occur
   always @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in)
         irq_mask <= `MASK_RESET;
      else if (wr_set)
         irq_mask <= irq_mask | (wb_dat_in & IRQ_VALID);
      else if (wr_clr)
         irq_mask <= irq_mask & ~(wb_dat_in & IRQ_VALID);
   end

   // =====================================================================
   // Bus answer and interrupt
   // =====================================================================
   // One wait state: ack comes the edge after the request is seen
   always @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h00000000;
         irq_out    <= 1'b0;
      end else begin
         wb_ack_out <= bus_req;
         irq_out    <= |(src_clean & irq_mask);
         if (bus_req && !wb_we_in) begin
            if (wb_adr_in == `OFS_IRQ_ENABLE_VIEW)
               wb_dat_out <= irq_mask;
            else if (wb_adr_in == `OFS_CHANNEL_STATUS)
               wb_dat_out <= status_word;
            else
               wb_dat_out <= 32'h00000000;
         end else begin
            wb_dat_out <= 32'h00000000;
         end
      end
   end

endmodule // serial_port_status_irq_unit

/* test/modem_line_model.sv */
// Far-side model of the four modem control lines feeding the status unit
`timescale 1ns/1ns
module modem_line_model (
   // Clock, reset and wanted levels: ring, dsr, dcd, cts
   input  logic       clock_in,
   input  logic       nrst_in,
   input  logic [3:0] want_in,
   // Modem pins
   output logic       ring_out,
   output logic       dsr_out,
   output logic       dcd_out,
   output logic       cts_out
);
   // Pins move just after an edge; the unit must still synchronise them as if they were free-running
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) {cts_out, dcd_out, dsr_out, ring_out} <= 4'h0;
      else {cts_out, dcd_out, dsr_out, ring_out} <= want_in;
   end
endmodule // modem_line_model

/* test/serial_status_asserts.sv */
// Concurrent checks on the ports of the serial port status and interrupt-mask unit
`timescale 1ns/1ns
module serial_status_asserts #(
   parameter HAS_MANCHESTER = 1,
   parameter HAS_FULL_MODEM = 1
) (
   // Clock, reset and Wishbone
   input logic        clock_in,
   input logic        nrst_in,
   input logic        wb_cyc_in,
   input logic        wb_stb_in,
   input logic        wb_we_in,
   input logic [3:0]  wb_adr_in,
   input logic [3:0]  wb_sel_in,
   input logic [31:0] wb_dat_in,
   input logic [31:0] wb_dat_out,
   input logic        wb_ack_out,
   // Watched levels and interrupt
   input logic        rx_enabled_in,
   input logic        timeout_zero_in,
   input logic        tx_enabled_in,
   input logic        tx_holding_full_in,
   input logic        start_break_cmd_in,
   input logic        rx_dma_done_in,
   input logic        irq_out
);
   localparam logic [31:0] VALID = 32'h00083FFF | (HAS_FULL_MODEM ? 32'h00070000 : 32'h0)
                                  | (HAS_MANCHESTER ? 32'h00100000 : 32'h0);
   logic [31:0] mask_m;
   default clocking @(posedge clock_in); endclocking
   default disable iff (!nrst_in);
   // Shadow of the mask; lets the view and the interrupt be judged without peeking inside
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) mask_m <= 32'h0;
      else if (wb_cyc_in && wb_stb_in && !wb_ack_out && wb_we_in && wb_sel_in == 4'hF)
         mask_m <= (wb_adr_in == 4'h0) ? (mask_m | (wb_dat_in & VALID)) :
                   (wb_adr_in == 4'h4) ? (mask_m & ~wb_dat_in) : mask_m;
   end
   sequence s_take;
      wb_cyc_in && wb_stb_in && !wb_ack_out;
   endsequence
   sequence s_rd_at(logic [3:0] a);
      s_take ##0 (!wb_we_in && wb_adr_in == a);
   endsequence
   chk_ack_next: assert property (s_take |=> wb_ack_out) else $error("ack late");
   chk_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack held");
   chk_idle_data: assert property (!wb_ack_out |-> wb_dat_out == 32'h0) else $error("data outside ack");
   chk_mask_view: assert property (s_rd_at(4'h8) |=> wb_dat_out == $past(mask_m))
      else $error("mask view wrong");
   chk_rx_dma_mirror: assert property (s_rd_at(4'hC) |=> wb_dat_out[3] == $past(rx_dma_done_in))
      else $error("rx dma bit wrong");
   chk_tx_ready: assert property (s_rd_at(4'hC) |=>
      wb_dat_out[1] == $past(tx_enabled_in && !tx_holding_full_in && !start_break_cmd_in)) else $error("tx ready wrong");
   chk_rx_off_zero: assert property ((!rx_enabled_in)[*2] ##0 s_rd_at(4'hC) |=> !wb_dat_out[0])
      else $error("rx ready while off");
   chk_tout_zero: assert property (timeout_zero_in[*2] ##0 s_rd_at(4'hC) |=> !wb_dat_out[8])
      else $error("timeout with zero value");
   chk_irq_masked: assert property (irq_out |-> $past(mask_m) != 32'h0)
      else $error("irq with empty mask");
endmodule // serial_status_asserts

bind serial_port_status_irq_unit serial_status_asserts #(.HAS_MANCHESTER(HAS_MANCHESTER),
   .HAS_FULL_MODEM(HAS_FULL_MODEM)) chk (.clock_in, .nrst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
   .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .rx_enabled_in, .timeout_zero_in, .tx_enabled_in,
   .tx_holding_full_in, .start_break_cmd_in, .rx_dma_done_in, .irq_out);

/* test/serial_port_status_irq_unit_tb_top.sv */
// Self-checking bench for the serial port status and interrupt-mask unit
`timescale 1ns/1ns
module serial_port_status_irq_unit_tb_top;
   logic        clock_in = 1'b0, nrst_in = 1'b0, wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
   logic [3:0]  wb_adr_in = 4'h0, wb_sel_in = 4'h0, pins = 4'h0;
   logic [31:0] wb_dat_in = 32'h0, wb_dat_out, q;
   logic        wb_ack_out, irq_out, ring, dsr, dcd, cts;
   logic [13:0] ev = 14'h0;   // Event and command pulses
   logic [10:0] lv = 11'h0;   // Receiver, transmitter and DMA levels
   int          n_mismatch = 0, checks = 0;
   always #10 clock_in = ~clock_in;
   serial_port_status_irq_unit dut (.clock_in, .nrst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
      .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .rx_enabled_in(lv[0]), .rx_char_done_in(ev[12]),
      .rx_holding_read_in(ev[13]), .rx_busy_in(lv[1]), .break_event_in(ev[0]), .overrun_event_in(ev[1]),
      .framing_event_in(ev[2]), .parity_event_in(ev[3]), .timeout_event_in(ev[4]), .start_timeout_in(ev[11]),
      .timeout_zero_in(lv[2]), .nonack_event_in(ev[5]), .iteration_event_in(ev[6]), .manchester_event_in(ev[7]),
      .tx_enabled_in(lv[3]), .tx_holding_full_in(lv[4]), .start_break_cmd_in(lv[5]), .tx_all_drained_in(lv[6]),
      .reset_status_cmd_in(ev[8]), .reset_nonack_cmd_in(ev[9]), .reset_repeat_cmd_in(ev[10]),
      .rx_dma_done_in(lv[7]), .tx_dma_done_in(lv[8]), .tx_dma_buffer_empty_in(lv[9]),
      .rx_dma_buffer_full_in(lv[10]), .ring_in(ring), .dsr_in(dsr), .dcd_in(dcd), .cts_in(cts), .irq_out);
   modem_line_model far (.clock_in, .nrst_in, .want_in(pins), .ring_out(ring), .dsr_out(dsr), .dcd_out(dcd),
      .cts_out(cts));
   // ==========================================================================
   // Bus and compare tasks
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One classic Wishbone cycle; waits for ack as long as it takes, the watchdog ends a hang
   task wb(input logic we, input logic [3:0] a, input logic [31:0] d);
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in <= we;
      wb_adr_in <= a;
      wb_dat_in <= d;
      wb_sel_in <= 4'hF;
      do begin
         @(posedge clock_in);
      end while (wb_ack_out !== 1'b1);
      q = wb_dat_out;
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
      @(posedge clock_in);
   endtask
   task rd(input logic [3:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   task pulse(input logic [13:0] m);
      ev <= m;
      @(posedge clock_in);
      ev <= 14'h0;
      @(posedge clock_in);
   endtask
   task setlv(input logic [10:0] v);
      lv <= v;
      @(posedge clock_in);
   endtask
   task end_sim;
      $display("mismatches=%0d checks=%0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ==========================================================================
   // Scenarios
   initial begin
      repeat (6) @(posedge clock_in);
      nrst_in <= 1'b1;
      @(posedge clock_in);
      rd(4'h8, 32'h0);
      wb(1'b1, 4'h0, 32'hFFFFFFFF);
      rd(4'h8, 32'h001F3FFF);
      wb(1'b1, 4'h4, 32'h00000005);
      wb(1'b1, 4'h8, 32'h00000000);
      rd(4'h8, 32'h001F3FFA);
      wb(1'b1, 4'h4, 32'hFFFFFFFF);
      rd(4'h2, 32'h0);
      pulse(14'h00FF);
      rd(4'hC, 32'h010025E4);
      pulse(14'h0100);
      rd(4'hC, 32'h00002500);
      pulse(14'h0200);
      rd(4'hC, 32'h00000500);
      pulse(14'h0400);
      rd(4'hC, 32'h00000100);
      setlv(11'h004);
      rd(4'hC, 32'h0);
      setlv(11'h000);
      pulse(14'h0800);
      rd(4'hC, 32'h0);
      setlv(11'h001);
      pulse(14'h1000);
      rd(4'hC, 32'h1);
      pulse(14'h2000);
      rd(4'hC, 32'h0);
      setlv(11'h003);
      setlv(11'h002);
      rd(4'hC, 32'h0);
      setlv(11'h001);
      rd(4'hC, 32'h1);
      pulse(14'h2000);
      setlv(11'h008);
      rd(4'hC, 32'h2);
      setlv(11'h058);
      rd(4'hC, 32'h200);
      setlv(11'h068);
      rd(4'hC, 32'h200);
      setlv(11'h780);
      rd(4'hC, 32'h1818);
      wb(1'b1, 4'h0, 32'h00000008);
      repeat (2) @(posedge clock_in);
      chk({31'h0, irq_out}, 32'h1);
      wb(1'b1, 4'h4, 32'h00000008);
      repeat (2) @(posedge clock_in);
      chk({31'h0, irq_out}, 32'h0);
      setlv(11'h000);
      pins <= 4'hF;
      repeat (6) @(posedge clock_in);
      rd(4'hC, 32'h00FF0000);
      pins <= 4'h8;
      repeat (6) @(posedge clock_in);
      rd(4'hC, 32'h00870000);
      rd(4'hC, 32'h00800000);
      end_sim;
   end
   // Watchdog: the scenarios need under two hundred cycles, far below its 5000, so this limit only trips on a hang
   initial begin
      #100000;
      n_mismatch++;
      end_sim;
   end
endmodule // serial_port_status_irq_unit_tb_top
